// ### core/sdc_channel.sv
// Purpose: one step/direction channel with remaining count, compare and rate reload
// Assumes: configuration inputs are stable flops from the top
// Notes: a software write beats a hardware update in the same cycle
`timescale 1ns/100ps
`default_nettype none

module sdc_channel (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // configuration
  input wire logic ch_enable,
  input wire logic cont_mode,
  input wire logic step_pol,
  input wire logic dir_pol,
  input wire logic clear_count,
  input wire logic reload_en,
  input wire logic [15:0] pulse_width,
  input wire logic [31:0] compare_val,
  input wire logic [31:0] queued_rate,
  // software writes
  input wire logic rate_wr,
  input wire logic target_wr,
  input wire logic [31:0] wdata,
  // driver pins
  output logic step_out,
  output logic step_out_inv,
  output logic dir_out,
  output logic dir_out_inv,
  // state for readback
  output logic [31:0] position,
  output logic [31:0] remaining
);
  logic [31:0] rate_reg, rate_next, acc_reg, acc_next;
  logic [31:0] pos_next, rem_next;
  logic [15:0] pulse_cnt_reg, pulse_cnt_next;

  wire [31:0] rate_mag = rate_reg[31] ? (~rate_reg + sdc_pkg::WORD_ONE) : rate_reg;
  wire [32:0] acc_sum = {1'b0, acc_reg} + {1'b0, rate_mag};
  // R2 stop at zero
  wire may_step = ch_enable & (cont_mode | (remaining != sdc_pkg::WORD_RST));
  wire step_evt = may_step & acc_sum[32];
  assign acc_next = may_step ? acc_sum[31:0] : acc_reg;

  // R13 up or down
  assign pos_next = clear_count ? sdc_pkg::WORD_RST :
                    !step_evt ? position :
                    rate_reg[31] ? position - sdc_pkg::WORD_ONE : position + sdc_pkg::WORD_ONE;
  // R5 R15 compare on change
  wire cmp_evt = step_evt & ~clear_count & (pos_next == compare_val);
  // R6 R7 R12 queued reload
  assign rate_next = rate_wr ? wdata : (cmp_evt & reload_en) ? queued_rate : rate_reg;
  // R1 R3 count down, rewrite
  assign rem_next = target_wr ? wdata :
                    (step_evt & ~cont_mode) ? remaining - sdc_pkg::WORD_ONE : remaining;
  assign pulse_cnt_next = step_evt ? pulse_width :
                          (pulse_cnt_reg != sdc_pkg::PW_ZERO) ? pulse_cnt_reg - sdc_pkg::PW_ONE : pulse_cnt_reg;
  wire pulse_on = pulse_cnt_next != sdc_pkg::PW_ZERO;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rate_reg <= sdc_pkg::WORD_RST;
      acc_reg <= sdc_pkg::WORD_RST;
      position <= sdc_pkg::WORD_RST;
      remaining <= sdc_pkg::WORD_RST;
      pulse_cnt_reg <= sdc_pkg::PW_ZERO;
      step_out <= 1'b0;
      step_out_inv <= 1'b1;
      dir_out <= 1'b0;
      dir_out_inv <= 1'b1;
    end else begin
      rate_reg <= rate_next;
      acc_reg <= acc_next;
      position <= pos_next;
      remaining <= rem_next;
      pulse_cnt_reg <= pulse_cnt_next;
      // R8 R9 R10 pulse width
      step_out <= pulse_on ^ step_pol;
      step_out_inv <= ~(pulse_on ^ step_pol);
      // R14 sign gives direction
      dir_out <= rate_next[31] ^ dir_pol;
      dir_out_inv <= ~(rate_next[31] ^ dir_pol);
    end
  end

  // -----------------------------------------------------------
  // checks
  // -----------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  AST_REM_DEC: assert property ( // R1
    step_evt && !cont_mode && !target_wr |=> remaining == $past(remaining) - sdc_pkg::WORD_ONE)
    else $error("remaining count not lowered by a step");
  AST_STOP_ZERO: assert property ( // R2
    remaining == sdc_pkg::WORD_RST && !cont_mode && !step_pol && pulse_cnt_reg == sdc_pkg::PW_ZERO
    |=> !step_out)
    else $error("step pulse issued with no steps remaining");
  AST_TGT_WR: assert property ( // R3
    target_wr |=> remaining == $past(wdata))
    else $error("written remaining count not taken");
  AST_READBACK: assert property ( // R4
    !target_wr && !step_evt |=> remaining == $past(remaining))
    else $error("remaining count moved without a step");
  AST_RELOAD: assert property ( // R6
    cmp_evt && reload_en && !rate_wr |=> rate_reg == $past(queued_rate))
    else $error("queued rate not loaded on compare");
  AST_NO_RELOAD: assert property ( // R12
    !reload_en && !rate_wr |=> rate_reg == $past(rate_reg))
    else $error("rate changed while reload disabled");
  // a following step may legally come right after the pulse, so only an undisturbed pulse is judged
  AST_PULSE: assert property ( // R8
    step_evt && pulse_width == 16'h0003 ##1 !step_evt[*3]
    |-> $past(step_out != step_pol, 2) && $past(step_out != step_pol) && (step_out != step_pol)
    ##1 step_out == step_pol)
    else $error("step pulse length differs from programmed");
  AST_POS_UP: assert property ( // R13
    step_evt && !clear_count && !rate_reg[31] |=> position == $past(position) + sdc_pkg::WORD_ONE)
    else $error("counter did not count up");
  AST_POS_DN: assert property ( // R13
    step_evt && !clear_count && rate_reg[31] |=> position == $past(position) - sdc_pkg::WORD_ONE)
    else $error("counter did not count down");
  AST_DIR: assert property ( // R14
    rate_wr |=> dir_out == ($past(wdata[31]) ^ $past(dir_pol)) && dir_out_inv == !dir_out)
    else $error("direction does not follow rate sign");

  COV_RELOAD: cover property (cmp_evt && reload_en);
  COV_DONE: cover property (step_evt && !cont_mode && remaining == sdc_pkg::WORD_ONE);
  COV_PULSE: cover property (step_evt ##1 step_out != step_pol);
endmodule

`default_nettype wire

// ### core/sdc_pkg.sv
// Purpose: shared constants for the three-channel step/direction compare block
// Assumes: registers are addressed by their index on a plain register port
// Notes: the wide pulse-width register is carried on a 48-bit data path
//
// Operation
// R1 - each channel keeps a 32-bit count of steps still to issue, lowered by one per step; in continuous mode the code leaves it unchanged.
// R2 - a channel whose remaining count is zero issues no more step pulses on either step output; in continuous mode the code keeps stepping at zero.
// R3 - software may rewrite the remaining count at any time and stepping continues from the new value.
// R4 - reading a step target register returns the steps still to go, not the value written.
// R5 - each channel holds a signed 32-bit compare value checked for equality against its step counter.
// R6 - on equality with the reload enable set, the queued rate replaces the active rate.
// R7 - each channel has a 32-bit writable queued rate that is copied into its rate on a compare event.
// R8 - channel 0 pulse width is bits 15:0 of the width register, in 25 MHz cycles.
// R9 - channel 1 pulse width is bits 31:16 of the width register, in 25 MHz cycles.
// R10 - channel 2 pulse width is bits 47:32 of the width register, in 25 MHz cycles.
// R11 - software must keep each pulse width shorter than the spacing between steps.
// R12 - channels 1 and 2 take their reload enable from configuration bits 14 and 22.
// R13 - each step counter moves up or down by one per step according to direction.
// R14 - the sign of the active rate sets the level of the direction output.
// R15 - compare is checked whenever the counter changes and a reloaded rate rules the next interval.

package sdc_pkg;
  localparam int NCH = 3;
  localparam int DW = 48;
  localparam int WORD = 32;
  localparam int PW = 16;
  // -----------------------------------------------------------
  // register indices, channel 0 of each per-channel group with channels following; width and configuration are single registers
  // -----------------------------------------------------------
  localparam logic [5:0] IDX_RATE0 = 6'h12;
  localparam logic [5:0] IDX_POS0 = 6'h15;
  localparam logic [5:0] IDX_TGT0 = 6'h18;
  localparam logic [5:0] IDX_CMP0 = 6'h1B;
  localparam logic [5:0] IDX_NEXT0 = 6'h1E;
  localparam logic [5:0] IDX_WIDTH = 6'h21;
  localparam logic [5:0] IDX_CFG = 6'h23;
  // -----------------------------------------------------------
  // configuration field layout, one byte per channel
  // -----------------------------------------------------------
  localparam int CFG_W = 24;
  localparam int CFG_STRIDE = 8;
  localparam int CFG_EN = 0;
  localparam int CFG_CONT = 1;
  localparam int CFG_SPOL = 2;
  localparam int CFG_DPOL = 3;
  localparam int CFG_CLR = 4;
  localparam int CFG_RELOAD = 6;
  localparam logic [CFG_W-1:0] CFG_RST = 24'h000000;
  localparam logic [WORD-1:0] WORD_RST = 32'h00000000;
  localparam logic [WORD-1:0] WORD_ONE = 32'h00000001;
  localparam logic [PW-1:0] PW_ZERO = 16'h0000;
  localparam logic [PW-1:0] PW_ONE = 16'h0001;
  localparam logic [DW-1:0] WIDTH_RST = 48'h000000000000;
endpackage

// ### core/sdc_top.sv
// Purpose: three-channel step/direction generator with target, compare and rate reload
// Assumes: register port is synchronous to clk_sys; index addressing
// Notes: reads answer one cycle after reg_rd; write-only registers read as zero
`timescale 1ns/100ps
`default_nettype none

module sdc_top (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // register port
  input wire logic [5:0] reg_index,
  input wire logic [47:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [47:0] reg_rdata,
  // driver pins, one bit per channel
  output logic [2:0] step_out,
  output logic [2:0] step_out_inv,
  output logic [2:0] dir_out,
  output logic [2:0] dir_out_inv
);
  // -----------------------------------------------------------
  // decode
  // -----------------------------------------------------------
  function automatic logic idx_hit(input logic [5:0] idx, input logic [5:0] base, input logic [1:0] ch);
    idx_hit = (idx == base + {4'h0, ch});
  endfunction

  logic [sdc_pkg::CFG_W-1:0] cfg_reg;
  logic [sdc_pkg::DW-1:0] width_reg;
  logic [31:0] cmp_reg [sdc_pkg::NCH];
  logic [31:0] next_reg [sdc_pkg::NCH];
  logic [31:0] pos_w [sdc_pkg::NCH];
  logic [31:0] rem_w [sdc_pkg::NCH];
  logic [47:0] rdata_next;

  wire cfg_wr = reg_wr & (reg_index == sdc_pkg::IDX_CFG);
  wire width_wr = reg_wr & (reg_index == sdc_pkg::IDX_WIDTH);

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cfg_reg <= sdc_pkg::CFG_RST;
      width_reg <= sdc_pkg::WIDTH_RST;
    end else begin
      if (cfg_wr) begin
        cfg_reg <= reg_wdata[sdc_pkg::CFG_W-1:0];
      end
      if (width_wr) begin
        width_reg <= reg_wdata;
      end
    end
  end

  // -----------------------------------------------------------
  // channels
  // -----------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < sdc_pkg::NCH; i = i + 1) begin : g_ch
      localparam logic [1:0] CH = 2'(i);
      localparam int CB = i * sdc_pkg::CFG_STRIDE;
      wire cmp_wr = reg_wr & idx_hit(reg_index, sdc_pkg::IDX_CMP0, CH);
      wire next_wr = reg_wr & idx_hit(reg_index, sdc_pkg::IDX_NEXT0, CH);

      // R5 R7 compare and queued rate
      always_ff @(posedge clk_sys) begin
        if (srst) begin
          cmp_reg[i] <= sdc_pkg::WORD_RST;
          next_reg[i] <= sdc_pkg::WORD_RST;
        end else begin
          if (cmp_wr) begin
            cmp_reg[i] <= reg_wdata[31:0];
          end
          if (next_wr) begin
            next_reg[i] <= reg_wdata[31:0];
          end
        end
      end

      // R8 R9 R10 R12 per-channel fields
      sdc_channel u_ch (
        .clk_sys(clk_sys),
        .srst(srst),
        .ch_enable(cfg_reg[CB + sdc_pkg::CFG_EN]),
        .cont_mode(cfg_reg[CB + sdc_pkg::CFG_CONT]),
        .step_pol(cfg_reg[CB + sdc_pkg::CFG_SPOL]),
        .dir_pol(cfg_reg[CB + sdc_pkg::CFG_DPOL]),
        .clear_count(cfg_reg[CB + sdc_pkg::CFG_CLR]),
        .reload_en(cfg_reg[CB + sdc_pkg::CFG_RELOAD]),
        .pulse_width(width_reg[i * sdc_pkg::PW +: sdc_pkg::PW]),
        .compare_val(cmp_reg[i]),
        .queued_rate(next_reg[i]),
        .rate_wr(reg_wr & idx_hit(reg_index, sdc_pkg::IDX_RATE0, CH)),
        .target_wr(reg_wr & idx_hit(reg_index, sdc_pkg::IDX_TGT0, CH)),
        .wdata(reg_wdata[31:0]),
        .step_out(step_out[i]),
        .step_out_inv(step_out_inv[i]),
        .dir_out(dir_out[i]),
        .dir_out_inv(dir_out_inv[i]),
        .position(pos_w[i]),
        .remaining(rem_w[i])
      );
    end
  endgenerate

  // -----------------------------------------------------------
  // readback
  // -----------------------------------------------------------
  // R4 target reads give steps still to go
  wire [1:0] rd_tgt_ch = 2'(reg_index - sdc_pkg::IDX_TGT0);
  wire [1:0] rd_pos_ch = 2'(reg_index - sdc_pkg::IDX_POS0);
  wire rd_tgt = (reg_index >= sdc_pkg::IDX_TGT0) && (reg_index < sdc_pkg::IDX_CMP0);
  wire rd_pos = (reg_index >= sdc_pkg::IDX_POS0) && (reg_index < sdc_pkg::IDX_TGT0);
  assign rdata_next = rd_tgt ? {16'h0000, rem_w[rd_tgt_ch]} :
                      rd_pos ? {16'h0000, pos_w[rd_pos_ch]} : 48'h000000000000;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      reg_rdata <= sdc_pkg::WIDTH_RST;
    end else if (reg_rd) begin
      reg_rdata <= rdata_next;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  AST_RD_TARGET: assert property ( // R4
    reg_rd && reg_index == sdc_pkg::IDX_TGT0 + 6'h02 |=> reg_rdata[31:0] == $past(rem_w[2]))
    else $error("target readback is not the remaining count");
  AST_WIDTH_CH2: assert property ( // R10
    width_wr |=> width_reg[47:32] == $past(reg_wdata[47:32]))
    else $error("channel 2 width field not stored");
  COV_RD: cover property (reg_rd && rd_tgt);
endmodule

`default_nettype wire

// ### tb/sdc_drv_model.sv
// Purpose: far-side stepper driver model, counting and timing step pulses
// Assumes: step polarity 0, so a step is a high pulse
// Notes: a driver only listens; nothing is driven back to the block
`timescale 1ns/100ps
`default_nettype none

module sdc_drv_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // driver pins
  input wire logic [2:0] step_in,
  input wire logic [2:0] step_in_inv,
  input wire logic [2:0] dir_in,
  input wire logic [2:0] dir_in_inv,
  // observations
  output logic [2:0][31:0] pulses,
  output logic [2:0][15:0] last_width,
  output logic [31:0] bad_pairs
);
  logic [2:0][15:0] run_len;

  // a pulse is counted on its falling edge, so its width is known by then
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pulses <= '0;
      last_width <= '0;
      run_len <= '0;
      bad_pairs <= 32'h00000000;
    end else begin
      for (int c = 0; c < 3; c++) begin
        if (step_in[c]) begin
          run_len[c] <= run_len[c] + 16'h0001;
        end else if (run_len[c] != 16'h0000) begin
          pulses[c] <= pulses[c] + 32'h00000001;
          last_width[c] <= run_len[c];
          run_len[c] <= 16'h0000;
        end
      end
      if ((step_in_inv !== ~step_in) || (dir_in_inv !== ~dir_in)) begin
        bad_pairs <= bad_pairs + 32'h00000001;
      end
    end
  end
endmodule
`default_nettype wire

// ### tb/tb.sv
// Purpose: self-checking bench for the step/direction compare block
// Assumes: register reads answer one cycle after the read strobe
// Notes: read results are checked through a queue of expected values
`timescale 1ns/100ps
`default_nettype none

module tb;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic [5:0] reg_index = 6'h00;
  logic [47:0] reg_wdata = 48'h000000000000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [47:0] reg_rdata;
  logic [2:0] step_out, step_out_inv, dir_out, dir_out_inv;
  logic [2:0][31:0] pulses;
  logic [2:0][15:0] last_width;
  logic [31:0] bad_pairs;
  logic [47:0] exp_q[$];
  logic rd_d = 1'b0;
  logic [15:0] w [3];
  logic [31:0] t [3];
  int n_fail = 0;
  int num_checks = 0;

  always #20 clk_sys = ~clk_sys;

  sdc_top sdc_top_inst (.clk_sys(clk_sys), .srst(srst), .reg_index(reg_index), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .step_out(step_out),
    .step_out_inv(step_out_inv), .dir_out(dir_out), .dir_out_inv(dir_out_inv));
  sdc_drv_model sdc_drv_model_inst (.clk_sys(clk_sys), .srst(srst), .step_in(step_out),
    .step_in_inv(step_out_inv), .dir_in(dir_out), .dir_in_inv(dir_out_inv), .pulses(pulses),
    .last_width(last_width), .bad_pairs(bad_pairs));

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic report_and_stop();
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [47:0] got, input logic [47:0] exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t %s got %h want %h", $time, msg, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [5:0] idx, input logic [47:0] data);
    @(posedge clk_sys);
    reg_index <= idx;
    reg_wdata <= data;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [5:0] idx, input logic [47:0] exp);
    @(posedge clk_sys);
    reg_index <= idx;
    reg_rd <= 1'b1;
    exp_q.push_back(exp);
    @(posedge clk_sys);
    reg_rd <= 1'b0;
  endtask

  task automatic do_reset();
    srst <= 1'b1;
    repeat (10) @(posedge clk_sys);
    srst <= 1'b0;
  endtask

  // read data lands one cycle after the strobe edge
  always @(posedge clk_sys) begin
    if (rd_d) begin
      chk(reg_rdata, exp_q.pop_front(), "read data");
    end
    rd_d <= reg_rd;
  end

  initial begin
    #(40 * 6000);
    n_fail++;
    $display("[ERR] %0t watchdog expired", $time);
    report_and_stop();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'hd3e0382e));
    do_reset();
    chk(48'({step_out, step_out_inv, dir_out, dir_out_inv}), 48'h0000000001C7, "reset pins");
    rd_reg(6'h22, 48'h000000000000);
    rd_reg(sdc_pkg::IDX_CMP0, 48'h000000000000);
    rd_reg(sdc_pkg::IDX_TGT0 + 6'h02, 48'h000000000000);
    // step spacing is 8 cycles, so widths stay at 7 or less
    for (int c = 0; c < 3; c++) begin
      w[c] = 16'(1 + $urandom % 7);
      t[c] = 32'(1 + $urandom % 8);
      wr_reg(sdc_pkg::IDX_RATE0 + 6'(c), 48'h000020000000);
      wr_reg(sdc_pkg::IDX_TGT0 + 6'(c), 48'(t[c]));
      rd_reg(sdc_pkg::IDX_TGT0 + 6'(c), 48'(t[c]));
    end
    wr_reg(sdc_pkg::IDX_WIDTH, {w[2], w[1], w[0]});
    wr_reg(sdc_pkg::IDX_CFG, 48'h000000010101);
    repeat (120) @(posedge clk_sys);
    for (int c = 0; c < 3; c++) begin
      chk(48'(pulses[c]), 48'(t[c]), "pulse count");
      chk(48'(last_width[c]), 48'(w[c]), "pulse width");
      rd_reg(sdc_pkg::IDX_TGT0 + 6'(c), 48'h000000000000);
      rd_reg(sdc_pkg::IDX_POS0 + 6'(c), 48'(t[c]));
    end
    wr_reg(sdc_pkg::IDX_TGT0 + 6'h02, 48'h000000000003);
    repeat (60) @(posedge clk_sys);
    chk(48'(pulses[2]), 48'(t[2] + 32'h00000003), "rewritten target");
    // reload on one channel at a time; the others must keep their rate
    for (int k = 0; k < 3; k++) begin
      do_reset();
      wr_reg(sdc_pkg::IDX_WIDTH, 48'h000100010001);
      for (int c = 0; c < 3; c++) begin
        wr_reg(sdc_pkg::IDX_RATE0 + 6'(c), 48'h000020000000);
        wr_reg(sdc_pkg::IDX_NEXT0 + 6'(c), 48'h0000E0000000);
        wr_reg(sdc_pkg::IDX_CMP0 + 6'(c), 48'h000000000003);
        wr_reg(sdc_pkg::IDX_TGT0 + 6'(c), 48'h00000000000A);
      end
      wr_reg(sdc_pkg::IDX_CFG, 48'h000000010101 | (48'h000000000040 << (8 * k)));
      repeat (200) @(posedge clk_sys);
      for (int c = 0; c < 3; c++) begin
        rd_reg(sdc_pkg::IDX_POS0 + 6'(c), (c == k) ? 48'h0000FFFFFFFC : 48'h00000000000A);
      end
      chk(48'({dir_out, dir_out_inv}), 48'({3'(1 << k), ~3'(1 << k)}), "direction");
      chk(48'(pulses[k]), 48'h00000000000A, "reload pulse count");
    end
    // continuous mode, direction and step polarity, and a held counter clear
    do_reset();
    wr_reg(sdc_pkg::IDX_WIDTH, 48'h000100010001);
    wr_reg(sdc_pkg::IDX_RATE0, 48'h000020000000);
    wr_reg(sdc_pkg::IDX_RATE0 + 6'h02, 48'h000020000000);
    wr_reg(sdc_pkg::IDX_TGT0 + 6'h02, 48'h000000000005);
    wr_reg(sdc_pkg::IDX_CFG, 48'h00000011040B);
    repeat (100) @(posedge clk_sys);
    wr_reg(sdc_pkg::IDX_CFG, 48'h000000000408);
    repeat (4) @(posedge clk_sys);
    chk(48'(pulses[0] > 32'h00000005), 48'h000000000001, "continuous past zero");
    rd_reg(sdc_pkg::IDX_TGT0, 48'h000000000000);
    rd_reg(sdc_pkg::IDX_POS0, 48'(pulses[0]));
    rd_reg(sdc_pkg::IDX_POS0 + 6'h02, 48'h000000000000);
    chk(48'(pulses[2]), 48'h000000000005, "steps while cleared");
    chk(48'({step_out, dir_out}), 48'h000000000011, "pin polarity");
    repeat (3) @(posedge clk_sys);
    chk(48'(bad_pairs), 48'h000000000000, "complement pins");
    report_and_stop();
  end
endmodule
`default_nettype wire
